// ==== nested_irq_priority_ctrl_tb.sv ====
// Self-checking bench for the priority controller
`timescale 1ns/1ps
module nested_irq_priority_ctrl_tb;
  logic core_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic flush = 1'b0, cpu_stopped, osc_stopped;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, pg = 8'h00, a;
  logic [10:0] raise = '0, irq_enable = '1, irq_pending, m;
  logic [7:0] spr [4] = '{default: 8'hff};
  logic [31:0] seed = 32'h0000e693;
  logic [1:0] cur_level;
  int num_errors = 0, n_tests = 0;
  nipc_pkg::nipc_instr_t instr = '0;
  nipc_pkg::nipc_take_t take_out;
  always #4 core_clk = ~core_clk;
  nipc_ctrl i_nipc_ctrl (.core_clk(core_clk), .arst_n(arst_n), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_pending(irq_pending),
    .irq_enable(irq_enable), .instr_boundary(1'b1), .instr(instr),
    .take_out(take_out), .cur_level(cur_level), .cpu_stopped(cpu_stopped),
    .osc_stopped(osc_stopped), .periph_gate());
  nipc_core_model i_nipc_core_model (.core_clk(core_clk), .arst_n(arst_n),
    .raise(raise), .flush(flush), .take_out(take_out),
    .irq_pending(irq_pending));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Level-0 pattern keeps the old field
  function automatic logic [7:0] nf(input logic [7:0] o, w);
    for (int i = 0; i < 8; i += 2) begin
      nf[i+:2] = w[i+:2] == 2'h2 ? o[i+:2] : w[i+:2];
    end
  endfunction : nf
  // Rank from encoding; strict compare keeps lowest index on ties
  function automatic logic [3:0] win(input logic [10:0] p);
    logic [1:0] f, b;
    win = 4'hf;
    b = 2'h0;
    for (int i = 1; i < 11; i++) begin
      f = spr[i/4][i%4*2+:2];
      if (p[i] && irq_enable[i] && {f[1] ~^ f[0], f[0]} > b) begin
        win = 4'(i);
        b = {f[1] ~^ f[0], f[0]};
      end
    end
  endfunction : win
  task automatic chk(input string n, input logic [7:0] s, e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    if (ad[7:2] == 6'h0b) begin
      spr[ad[1:0]] = nf(spr[ad[1:0]], d);
      if (ad[1:0] == 2'h3) spr[3] = spr[3] | 8'hf0;
    end
    if (ad == 8'h30) pg = d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // Idle edge so a following call never reassigns the strobe
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] ad, e);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
    @(posedge core_clk);
  endtask : rd
  task automatic ins(input nipc_pkg::nipc_instr_t v);
    instr <= v;
    @(posedge core_clk);
    instr <= '0;
    @(posedge core_clk);
    #1;
  endtask : ins
  task automatic rs(input logic [10:0] r);
    raise <= r;
    @(posedge core_clk);
    raise <= '0;
    #1;
  endtask : rs
  task automatic wt(input logic [3:0] e);
    int n;
    n = 0;
    while (take_out.take !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk("vector", n < 20 ? 8'(take_out.vector) : 8'h0f, 8'(e));
    flush <= 1'b1;
    @(posedge core_clk);
    flush <= 1'b0;
  endtask : wt
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000 num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    for (int k = 0; k < 5; k++) begin
      rd(8'h2c + 8'(k), k == 4 ? 8'h00 : 8'hff);
    end
    wr(8'h2c, 8'hcf);
    wr(8'h2c, 8'h64);
    rd(8'h2c, 8'h44);
    wr(8'h40, 8'h5a);
    rd(8'h40, 8'h00);
    repeat (12) begin
      a = 8'h2c + 8'(xs() % 5);
      wr(a, 8'(xs()));
      rd(a, a == 8'h30 ? pg : spr[a[1:0]]);
    end
    repeat (8) begin
      for (int k = 0; k < 3; k++) wr(8'h2c + 8'(k), 8'(xs()));
      irq_enable <= 11'(xs());
      ins(9'h100);
      chk("level", 8'(cur_level), 8'h02);
      m = 11'(xs()) & 11'h7fe;
      rs(m);
      wt(win(m));
    end
    irq_enable <= '1;
    rs(11'h001);
    wt(4'h0);
    ins(9'h040);
    ins(9'h009);
    chk("level", 8'(cur_level), 8'h01);
    ins(9'h080);
    chk("level", 8'(cur_level), 8'h03);
    ins(9'h020);
    chk("stopped", 8'(cpu_stopped), 8'h01);
    rs(11'h008);
    wt(4'h3);
    ins(9'h010);
    chk("osc", 8'(osc_stopped), 8'h01);
    rs(11'h008);
    wt(4'hf);
    rs(11'h408);
    wt(4'ha);
    tally_and_finish();
  end
endmodule : nested_irq_priority_ctrl_tb
bind nipc_ctrl nipc_props i_nipc_props (.core_clk(core_clk),
  .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .instr_boundary(instr_boundary), .instr(instr),
  .take_out(take_out), .cur_level(cur_level), .cpu_stopped(cpu_stopped));

// ==== nipc_core_model.sv ====
// Core and peripheral side: latches requests, drops each one when taken
`timescale 1ns/1ps
module nipc_core_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [10:0] raise,
  input wire logic flush,
  input wire nipc_pkg::nipc_take_t take_out,
  output logic [10:0] irq_pending
);
  wire [10:0] done = take_out.take ? 11'h001 << take_out.vector : 11'h000;
  // Issues no instructions, so no handler overwrites the level
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_pending <= 11'h000;
    end else begin
      irq_pending <= flush ? 11'h000 : (irq_pending | raise) & ~done;
    end
  end
endmodule : nipc_core_model

// ==== nipc_ctrl.sv ====
// Nested interrupt priority controller: registers, arbitration, CC bits
//
// Functional notes
// - All four priority registers reset to ff, every vector at level 3.
// - Upper nibble of fourth register reads one, read-only; rest read-write.
// - Each vector except reset and trap owns a two-bit field in order.
// - Stored fields use the same encoding as condition-code priority bits.
// - Writing level-0 pattern to a field keeps that field's old value.
// - Reset, trap and top-level interrupt set current priority to level 3.
// - Top-level field stays read-write but never affects arbitration.
// - Raising priority of executing pending interrupt re-enters it.
// - Unmask, halt and wait instructions load level 0 encoding 10.
// - Mask-all and trap instructions load encoding 11, level 3.
// - Interrupt return restores the previous current-priority bits.
// - Fixed order: reset, trap, flash NMI, then sources 1 to 10.
// - Only listed sources may end HALT; trap and others may not.
// - After reset the part runs in normal mode on the CPU clock.
// - Wait stops the CPU while peripherals keep running.
// - Entering wait forces current priority bits to level 0.
// - Wait lasts until any interrupt or reset, then vector is taken.
// - Software can gate unused peripherals individually.
// - Highest software priority wins; ties go to fixed hardware order.
// - Maskable request served if enabled and above current priority.
// - On maskable entry current priority loads the vector's field.
`timescale 1ns/1ps
module nipc_ctrl (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [nipc_pkg::NSRC-1:0] irq_pending,
  input wire logic [nipc_pkg::NSRC-1:0] irq_enable,
  input wire logic instr_boundary,
  input wire nipc_pkg::nipc_instr_t instr,
  output nipc_pkg::nipc_take_t take_out,
  output logic [1:0] cur_level,
  output logic cpu_stopped,
  output logic osc_stopped,
  output logic [7:0] periph_gate
);
  logic [7:0] spr_q [4];
  logic [7:0] spr_d [4];
  logic [1:0] cc_q, cc_d;
  logic [7:0] pgate_q, pgate_d;
  logic [7:0] rdata_q, rdata_d;
  nipc_pkg::nipc_mode_t mode_q, mode_d;
  nipc_pkg::nipc_take_t take_q, take_d;
  logic [1:0] field [nipc_pkg::NFIELD];
  logic [nipc_pkg::NSRC-1:0] eligible;
  logic [2:0] rank [nipc_pkg::NSRC];
  logic [2:0] best_rank;
  logic [3:0] best_idx;
  logic wake_any;
  logic take_now;
  logic [7:0] rd_mux;

  // Map encoded level to a numeric rank; level 3 encoded 11 is highest
  function automatic logic [2:0] lvl_rank(input logic [1:0] e);
    case (e)
      nipc_pkg::LVL0: lvl_rank = 3'h1;
      nipc_pkg::LVL1: lvl_rank = 3'h2;
      nipc_pkg::LVL2: lvl_rank = 3'h3;
      default: lvl_rank = 3'h4;
    endcase
  endfunction : lvl_rank

  // Per-field write that refuses the level-0 pattern
  function automatic logic [7:0] prot_wr(input logic [7:0] old_v,
                                          input logic [7:0] new_v);
    logic [7:0] r;
    r = new_v;
    for (int i = 0; i < 4; i++) begin
      if (new_v[2*i +: 2] == nipc_pkg::LVL0) begin
        r[2*i +: 2] = old_v[2*i +: 2];
      end
    end
    prot_wr = r;
  endfunction : prot_wr

  // Fields in vector order, lowest bits of first register first
  genvar g;
  generate
    for (g = 0; g < nipc_pkg::NFIELD; g++) begin : g_field
      assign field[g] = spr_q[g/4][2*(g%4) +: 2];
    end
  endgenerate

  // Sources 1..10 are maskable; flash NMI (0) is the top-level one
  wire halted = (mode_q == nipc_pkg::NIPC_HALT);
  generate
    for (g = 0; g < nipc_pkg::NSRC; g++) begin : g_elig
      if (g == nipc_pkg::TOP_FIELD) begin : g_top
        assign rank[g] = 3'h5;
        assign eligible[g] = irq_pending[g]
          && (!halted || nipc_pkg::HALT_WAKE_MASK[g]);
      end else begin : g_mask
        assign rank[g] = lvl_rank(field[g]);
        // Enabled and strictly above current level
        assign eligible[g] = irq_pending[g] && irq_enable[g]
          && (lvl_rank(field[g]) > lvl_rank(cc_q))
          && (!halted || nipc_pkg::HALT_WAKE_MASK[g]);
      end
    end
  endgenerate

  // Highest rank wins, lower index breaks ties
  always_comb begin
    best_rank = 3'h0;
    best_idx = nipc_pkg::VEC_NONE;
    for (int i = nipc_pkg::NSRC - 1; i >= 0; i--) begin
      if (eligible[i] && rank[i] >= best_rank) begin
        best_rank = rank[i];
        best_idx = 4'(i);
      end
    end
  end

  assign wake_any = (best_idx != nipc_pkg::VEC_NONE);
  // Taken at a boundary, or straight out of a low-power mode
  assign take_now = wake_any && (instr_boundary
    || mode_q != nipc_pkg::NIPC_RUN);

  // Current priority bits sequencing
  always_comb begin
    cc_d = cc_q;
    take_d = '0;
    take_d.vector = nipc_pkg::VEC_NONE;
    mode_d = mode_q;
    if (instr.trap && instr_boundary) begin
      cc_d = nipc_pkg::LVL3;
      take_d.take = 1'b1;
      take_d.vector = nipc_pkg::VEC_TRAP;
      take_d.new_level = nipc_pkg::LVL3;
    end else if (take_now) begin
      cc_d = (best_idx == 4'(nipc_pkg::TOP_FIELD)) ? nipc_pkg::LVL3
           : field[best_idx];
      take_d.take = 1'b1;
      take_d.vector = best_idx;
      take_d.new_level = cc_d;
      mode_d = nipc_pkg::NIPC_RUN;
    end else if (instr.isr_return || instr.pop_cc) begin
      cc_d = instr.popped_level;
    end else if (instr.mask_all) begin
      cc_d = nipc_pkg::LVL3;
    end else if (instr.unmask) begin
      cc_d = nipc_pkg::LVL0;
    end else if (instr.wait_entry) begin
      cc_d = nipc_pkg::LVL0;
      mode_d = nipc_pkg::NIPC_WAIT;
    end else if (instr.halt_entry) begin
      cc_d = nipc_pkg::LVL0;
      mode_d = nipc_pkg::NIPC_HALT;
    end
  end

  // Register writes; upper nibble of fourth register fixed
  wire wr0 = reg_wr && reg_addr == nipc_pkg::ADDR_SPR0;
  wire wr1 = reg_wr && reg_addr == nipc_pkg::ADDR_SPR1;
  wire wr2 = reg_wr && reg_addr == nipc_pkg::ADDR_SPR2;
  wire wr3 = reg_wr && reg_addr == nipc_pkg::ADDR_SPR3;
  wire wrg = reg_wr && reg_addr == nipc_pkg::ADDR_PGATE;
  assign spr_d[0] = wr0 ? prot_wr(spr_q[0], reg_wdata) : spr_q[0];
  assign spr_d[1] = wr1 ? prot_wr(spr_q[1], reg_wdata) : spr_q[1];
  assign spr_d[2] = wr2 ? prot_wr(spr_q[2], reg_wdata) : spr_q[2];
  assign spr_d[3] = wr3 ? (prot_wr(spr_q[3], reg_wdata)
    | nipc_pkg::SPR3_RO_MASK) : spr_q[3];
  assign pgate_d = wrg ? reg_wdata : pgate_q;

  // Read mux; unmapped addresses read zero
  assign rd_mux =
    (reg_addr == nipc_pkg::ADDR_SPR0) ? spr_q[0] :
    (reg_addr == nipc_pkg::ADDR_SPR1) ? spr_q[1] :
    (reg_addr == nipc_pkg::ADDR_SPR2) ? spr_q[2] :
    (reg_addr == nipc_pkg::ADDR_SPR3) ? spr_q[3] :
    (reg_addr == nipc_pkg::ADDR_PGATE) ? pgate_q :
    (reg_addr == nipc_pkg::ADDR_STAT) ? {4'h0, mode_q, cc_q} : 8'h00;
  assign rdata_d = reg_rd ? rd_mux : 8'h00;

  // Reset puts all fields at level 3, CC at level 3, run mode
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        spr_q[i] <= nipc_pkg::SPR_RST;
      end
      cc_q <= nipc_pkg::LVL3;
      pgate_q <= nipc_pkg::PGATE_RST;
      rdata_q <= 8'h00;
      mode_q <= nipc_pkg::NIPC_RUN;
      take_q <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < 4; i++) begin
        spr_q[i] <= spr_d[i];
      end
      cc_q <= cc_d;
      pgate_q <= pgate_d;
      rdata_q <= rdata_d;
      mode_q <= mode_d;
      take_q <= take_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign take_out = take_q;
  assign cur_level = cc_q;
  assign cpu_stopped = (mode_q != nipc_pkg::NIPC_RUN);
  assign osc_stopped = halted;
  assign periph_gate = pgate_q;
endmodule : nipc_ctrl

// ==== nipc_ctrl_properties.sv ====
// Port-level assertions for the priority controller
`timescale 1ns/1ps
module nipc_props (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic instr_boundary,
  input wire nipc_pkg::nipc_instr_t instr,
  input wire nipc_pkg::nipc_take_t take_out,
  input wire logic [1:0] cur_level,
  input wire logic cpu_stopped
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  wire hi = instr.trap | instr.isr_return | instr.pop_cc;
  wire rd3 = reg_rd & clk_en & (reg_addr == nipc_pkg::ADDR_SPR3);
  wire [1:0] pl = instr.popped_level;
  wire tk = take_out.take;
  wire [3:0] vec = take_out.vector;
  a_spr3_upper:
    assert property ($past(rd3) |-> reg_rdata[7:4] == 4'hf) else $error("nib");
  a_trap_take:
    assert property (instr.trap && instr_boundary && clk_en |=> tk
      && vec == nipc_pkg::VEC_TRAP && cur_level == 2'h3) else $error("trap");
  a_unmask_lvl:
    assert property (instr.unmask && !instr.mask_all && !hi && clk_en
      |=> tk || cur_level == 2'h2) else $error("unmask");
  a_mask_lvl:
    assert property (instr.mask_all && !hi && clk_en
      |=> tk || cur_level == 2'h3) else $error("mask");
  a_wait_lvl:
    assert property (instr.wait_entry && !instr.unmask && !instr.mask_all
      && !hi && clk_en |=> tk || (cur_level == 2'h2 && cpu_stopped))
      else $error("wait");
  a_return_lvl:
    assert property ((instr.isr_return || instr.pop_cc) && !instr.trap
      && clk_en |=> tk || cur_level == $past(pl)) else $error("ret");
  a_take_lvl:
    assert property (tk && vec inside {[4'h1:4'ha]}
      |-> cur_level == take_out.new_level) else $error("take");
  a_nmi_lvl:
    assert property (tk && vec == 4'h0 |-> cur_level == 2'h3
      && take_out.new_level == 2'h3) else $error("nmi");
endmodule : nipc_props

// ==== nipc_pkg.sv ====
// Package for the nested interrupt priority controller
package nipc_pkg;
  localparam logic [7:0] ADDR_SPR0 = 8'h2c;
  localparam logic [7:0] ADDR_SPR1 = 8'h2d;
  localparam logic [7:0] ADDR_SPR2 = 8'h2e;
  localparam logic [7:0] ADDR_SPR3 = 8'h2f;
  localparam logic [7:0] ADDR_PGATE = 8'h30;
  localparam logic [7:0] ADDR_STAT = 8'h31;
  localparam logic [7:0] SPR_RST = 8'hff;
  localparam logic [7:0] SPR3_RO_MASK = 8'hf0;
  localparam logic [7:0] PGATE_RST = 8'h00;
  localparam int NSRC = 11;
  localparam int NFIELD = 14;
  localparam int TOP_FIELD = 0;
  // Encoded levels, same as the two condition-code priority bits
  localparam logic [1:0] LVL0 = 2'h2;
  localparam logic [1:0] LVL1 = 2'h1;
  localparam logic [1:0] LVL2 = 2'h0;
  localparam logic [1:0] LVL3 = 2'h3;
  // Sources 1..10 that may end HALT: cable, port A, resume, D, C, serial
  localparam logic [NSRC-1:0] HALT_WAKE_MASK = 11'h667;
  localparam logic [3:0] VEC_NONE = 4'hf;
  localparam logic [3:0] VEC_RESET = 4'he;
  localparam logic [3:0] VEC_TRAP = 4'hd;

  typedef enum logic [1:0] {
    NIPC_RUN = 2'b00,
    NIPC_WAIT = 2'b01,
    NIPC_HALT = 2'b11
  } nipc_mode_t;

  typedef struct packed {
    logic take;
    logic [3:0] vector;
    logic [1:0] new_level;
  } nipc_take_t;

  typedef struct packed {
    logic unmask;
    logic mask_all;
    logic trap;
    logic wait_entry;
    logic halt_entry;
    logic isr_return;
    logic pop_cc;
    logic [1:0] popped_level;
  } nipc_instr_t;
endpackage : nipc_pkg
